// ---- hdl/fss_pkg.sv ----
// Package for the fieldbus slave state machine: states, codes, layout constants.
// Assumes a single 100 MHz clock domain and synchronous active-high reset.
package fss_pkg;

  // ---------------------------------------------------------------------------
  // State encoding (Gray along init -> pre_operational_state -> safe_operational_state -> op)
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FSS_INIT    = 3'h0,
    FSS_PRE_OPERATIONAL_STATE  = 3'h1,
    FSS_SAFE_OPERATIONAL_STATE = 3'h3,
    FSS_OP      = 3'h2,
    FSS_BOOT    = 3'h6
  } fss_state_t;

  // ---------------------------------------------------------------------------
  // Error codes reported to the master
  // ---------------------------------------------------------------------------
  localparam logic [2:0] FSS_ERR_NONE     = 3'h0;
  localparam logic [2:0] FSS_ERR_ILLEGAL  = 3'h1;
  localparam logic [2:0] FSS_ERR_MBX_CFG  = 3'h2;
  localparam logic [2:0] FSS_ERR_PD_CFG   = 3'h3;
  localparam logic [2:0] FSS_ERR_DC_CFG   = 3'h4;
  localparam logic [2:0] FSS_ERR_NO_OUT   = 3'h5;

  // ---------------------------------------------------------------------------
  // Widths and parameter object layout
  // ---------------------------------------------------------------------------
  localparam int          FSS_PD_W        = 16;
  localparam logic [15:0] FSS_SAFE_OUT    = 16'h0000;
  localparam logic [15:0] FSS_CH_BASE     = 16'h8000;
  localparam logic [15:0] FSS_CH_STEP     = 16'h0010;
  localparam logic [7:0]  FSS_SUB_MAX     = 8'hff;
  localparam logic [15:0] FSS_IN_OBJ_BASE = 16'h6000;
  localparam logic [15:0] FSS_OUT_OBJ_BASE= 16'h7000;

  // Master request and configuration status, sampled together
  typedef struct packed {
    logic       valid;
    fss_state_t target;
    logic       mbx_cfg_ok;
    logic       pd_cfg_ok;
    logic       dc_used;
    logic       dc_cfg_ok;
    logic       out_valid;
  } fss_req_t;

  // Traffic permissions
  typedef struct packed {
    logic mbx_any;
    logic mbx_file;
    logic pd;
  } fss_perm_t;

endpackage : fss_pkg

// ---- hdl/fss_obj_map.sv ----
// Parameter object index mapper: channel/area to object index.
// Assumes synchronous inputs; registered outputs.
`timescale 1ns/100ps
`default_nettype none
module fss_obj_map
  import fss_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [1:0]  area_in,
  input  wire logic [7:0]  chan_in,
  input  wire logic [7:0]  sub_in,
  output logic      [15:0] index_out,
  output logic             sub_ok_out
);

  // ---------------------------------------------------------------------------
  // Channel base arithmetic
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] fss_chan_index(input logic [15:0] base,
                                                 input logic [7:0]  ch);
    fss_chan_index = base + 16'(ch) * FSS_CH_STEP;
  endfunction : fss_chan_index

  // channel block layout, process object areas
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      index_out  <= 16'h0000;
      sub_ok_out <= 1'b0;
    end else begin
      case (area_in)
        2'h1:    index_out <= fss_chan_index(FSS_IN_OBJ_BASE, chan_in);
        2'h2:    index_out <= fss_chan_index(FSS_OUT_OBJ_BASE, chan_in);
        default: index_out <= fss_chan_index(FSS_CH_BASE, chan_in);
      endcase
      sub_ok_out <= (sub_in <= FSS_SUB_MAX);
    end
  end

endmodule : fss_obj_map
`default_nettype wire

// ---- hdl/fss_slave_sm.sv ----
// Fieldbus slave communication state machine with output and input handling.
// Assumes the master's request and its config status arrive synchronously.
`timescale 1ns/100ps
`default_nettype none
module fss_slave_sm
  import fss_pkg::*;
(
  input  wire logic                ref_clk_in,
  input  wire logic                sys_rst_in,
  input  wire fss_req_t            req_in,
  input  wire logic                err_ack_in,
  input  wire logic                wdog_en_in,
  input  wire logic                wdog_trip_in,
  input  wire logic                cycle_in,
  input  wire logic [FSS_PD_W-1:0] phys_in,
  input  wire logic [FSS_PD_W-1:0] master_out_in,
  input  wire logic [1:0]          area_in,
  input  wire logic [7:0]          chan_in,
  input  wire logic [7:0]          sub_in,
  output fss_state_t               state_out,
  output logic                     ack_out,
  output logic                     err_out,
  output logic [2:0]               err_code_out,
  output fss_perm_t                perm_out,
  output logic [FSS_PD_W-1:0]      phys_out,
  output logic [FSS_PD_W-1:0]      dpm_in_out,
  output logic                     dpm_wr_out,
  output logic [15:0]              index_out,
  output logic                     sub_ok_out
);

  // ---------------------------------------------------------------------------
  // State and request checking
  // ---------------------------------------------------------------------------
  fss_state_t state;
  fss_state_t next_state;
  logic [2:0] next_err;
  logic       accept;
  logic       snap_pending;

  // Legality and config checks for the requested move
  always_comb begin
    next_state = state;
    next_err   = FSS_ERR_NONE;
    accept     = 1'b0;
    case (state)
      FSS_INIT: begin
        if (req_in.target == FSS_PRE_OPERATIONAL_STATE) begin
          if (req_in.mbx_cfg_ok) accept = 1'b1;
          else next_err = FSS_ERR_MBX_CFG;
        end else if (req_in.target == FSS_BOOT) begin
          if (req_in.mbx_cfg_ok) accept = 1'b1;
          else next_err = FSS_ERR_MBX_CFG;
        end else if (req_in.target == FSS_INIT) begin
          accept = 1'b1;
        end else begin
          next_err = FSS_ERR_ILLEGAL;
        end
      end
      FSS_PRE_OPERATIONAL_STATE: begin
        if (req_in.target == FSS_SAFE_OPERATIONAL_STATE) begin
          if (!req_in.pd_cfg_ok) next_err = FSS_ERR_PD_CFG;
          else if (req_in.dc_used && !req_in.dc_cfg_ok) next_err = FSS_ERR_DC_CFG;
          else accept = 1'b1;
        end else if (req_in.target == FSS_INIT || req_in.target == FSS_PRE_OPERATIONAL_STATE) begin
          accept = 1'b1;
        end else begin
          next_err = FSS_ERR_ILLEGAL;
        end
      end
      FSS_SAFE_OPERATIONAL_STATE: begin
        if (req_in.target == FSS_OP) begin
          if (req_in.out_valid) accept = 1'b1;
          else next_err = FSS_ERR_NO_OUT;
        end else if (req_in.target inside {FSS_INIT, FSS_PRE_OPERATIONAL_STATE, FSS_SAFE_OPERATIONAL_STATE}) begin
          // downward moves or a repeat of safe_operational_state; boot and unused codes refused
          accept = 1'b1;
        end else begin
          next_err = FSS_ERR_ILLEGAL;
        end
      end
      FSS_OP: begin
        // no path to boot; an unused code would leave the legal states
        if (req_in.target inside {FSS_INIT, FSS_PRE_OPERATIONAL_STATE, FSS_SAFE_OPERATIONAL_STATE, FSS_OP}) accept = 1'b1;
        else next_err = FSS_ERR_ILLEGAL;
      end
      FSS_BOOT: begin
        if (req_in.target == FSS_INIT || req_in.target == FSS_BOOT) accept = 1'b1;
        else next_err = FSS_ERR_ILLEGAL;
      end
      default: next_err = FSS_ERR_ILLEGAL;
    endcase
    if (accept) next_state = req_in.target;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // init after reset; op is held until the master asks otherwise
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state <= FSS_INIT;
    end else if (req_in.valid && accept && !snap_pending) begin
      state <= next_state;
    end
  end

  // Safe_operational_state acknowledge from pre_operational_state waits one cycle so it lands with the input snapshot
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      snap_pending <= 1'b0;
    end else begin
      snap_pending <= req_in.valid && accept && !snap_pending &&
                      state == FSS_PRE_OPERATIONAL_STATE && next_state == FSS_SAFE_OPERATIONAL_STATE;
    end
  end

  // Acknowledge pulse: immediately for most moves, together with the snapshot for pre_operational_state to safe_operational_state
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= snap_pending ||
                 (req_in.valid && accept && !snap_pending &&
                  !(state == FSS_PRE_OPERATIONAL_STATE && next_state == FSS_SAFE_OPERATIONAL_STATE));
    end
  end

  // ---------------------------------------------------------------------------
  // Error indication
  // ---------------------------------------------------------------------------
  // state kept, sticky error; a new failure wins over the clear
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      err_out      <= 1'b0;
      err_code_out <= FSS_ERR_NONE;
    end else if (req_in.valid && !accept && !snap_pending) begin
      err_out      <= 1'b1;
      err_code_out <= next_err;
    end else if (err_ack_in) begin
      err_out      <= 1'b0;
      err_code_out <= FSS_ERR_NONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Traffic permissions
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      perm_out <= '0;
    end else begin
      case (state)
        FSS_PRE_OPERATIONAL_STATE:  perm_out <= '{mbx_any: 1'b1, mbx_file: 1'b1, pd: 1'b0};
        FSS_SAFE_OPERATIONAL_STATE: perm_out <= '{mbx_any: 1'b1, mbx_file: 1'b1, pd: 1'b1};
        FSS_OP:      perm_out <= '{mbx_any: 1'b1, mbx_file: 1'b1, pd: 1'b1};
        FSS_BOOT:    perm_out <= '{mbx_any: 1'b0, mbx_file: 1'b1, pd: 1'b0};
        default:     perm_out <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs and inputs
  // ---------------------------------------------------------------------------
  // watchdog forces safe value; op follows master data
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      phys_out <= FSS_SAFE_OUT;
    end else if (wdog_en_in && wdog_trip_in) begin
      phys_out <= FSS_SAFE_OUT;
    end else if (state == FSS_OP) begin
      phys_out <= master_out_in;
    end else if (state == FSS_SAFE_OPERATIONAL_STATE && !wdog_en_in) begin
      phys_out <= master_out_in;
    end else begin
      phys_out <= FSS_SAFE_OUT;
    end
  end

  // cyclic input refresh; snapshot on safe_operational_state entry from pre_operational_state
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      dpm_in_out <= '0;
      dpm_wr_out <= 1'b0;
    end else if (snap_pending ||
                 (cycle_in && (state == FSS_SAFE_OPERATIONAL_STATE || state == FSS_OP))) begin
      dpm_in_out <= phys_in;
      dpm_wr_out <= 1'b1;
    end else begin
      dpm_wr_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Parameter object index mapping
  // ---------------------------------------------------------------------------
  fss_obj_map u_obj_map (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .area_in    (area_in),
    .chan_in    (chan_in),
    .sub_in     (sub_in),
    .index_out  (index_out),
    .sub_ok_out (sub_ok_out)
  );

  assign state_out = state;

endmodule : fss_slave_sm
`default_nettype wire

// ---- tb/fss_slave_sm_monitor.sv ----
// Checker for fss_slave_sm: traffic per state, state entry and outputs.
// Sees only ports of fss_slave_sm; bound to it at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module fss_slave_sm_monitor
  import fss_pkg::*;
(
  input wire logic                ref_clk_in,
  input wire logic                sys_rst_in,
  input wire logic                wdog_en_in,
  input wire fss_state_t          state_out,
  input wire logic                ack_out,
  input wire logic                err_out,
  input wire fss_perm_t           perm_out,
  input wire logic [FSS_PD_W-1:0] phys_out,
  input wire logic                dpm_wr_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Permissions lag the state by a cycle, so a state is judged once held
  sequence s_in(fss_state_t s); (state_out == s) [*2]; endsequence
  sequence s_to_safe; state_out == FSS_PRE_OPERATIONAL_STATE ##1 state_out == FSS_SAFE_OPERATIONAL_STATE; endsequence
  property p_init_quiet; s_in(FSS_INIT) |-> perm_out == 3'h0; endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("init traffic open");
  property p_pre_mbx; s_in(FSS_PRE_OPERATIONAL_STATE) |-> perm_out.mbx_any && !perm_out.pd; endproperty
  a_pre_mbx: assert property (p_pre_mbx) else $error("pre_operational_state traffic wrong");
  property p_safe_all; s_in(FSS_SAFE_OPERATIONAL_STATE) |-> perm_out.mbx_any && perm_out.pd; endproperty
  a_safe_all: assert property (p_safe_all) else $error("safe_operational_state traffic wrong");
  property p_safe_out;
    (state_out == FSS_SAFE_OPERATIONAL_STATE && wdog_en_in) [*2] |-> phys_out == FSS_SAFE_OUT;
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("safe_operational_state outputs live");
  property p_boot_file; s_in(FSS_BOOT) |-> perm_out == 3'h2; endproperty
  a_boot_file: assert property (p_boot_file) else $error("boot traffic wrong");
  property p_boot_entry;
    $changed(state_out) && state_out == FSS_BOOT |-> $past(state_out) == FSS_INIT;
  endproperty
  a_boot_entry: assert property (p_boot_entry) else $error("boot not from init");
  // Snapshot write and acknowledge come together one cycle after entry
  property p_snap; s_to_safe |=> ack_out && dpm_wr_out; endproperty
  a_snap: assert property (p_snap) else $error("safe_operational_state entry not acked");
  property p_err_hold; $rose(err_out) && !$past(ack_out) |-> $stable(state_out); endproperty
  a_err_hold: assert property (p_err_hold) else $error("state moved on error");
endmodule : fss_slave_sm_monitor
bind fss_slave_sm fss_slave_sm_monitor u_mon (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .wdog_en_in(wdog_en_in), .state_out(state_out),
  .ack_out(ack_out), .err_out(err_out), .perm_out(perm_out), .phys_out(phys_out),
  .dpm_wr_out(dpm_wr_out));
`default_nettype wire

// ---- tb/fss_master_model.sv ----
// Model of the fieldbus master: one state request at a time.
// Assumes the slave takes a request on any edge with valid high and no safe_operational_state snapshot pending.
`timescale 1ns/100ps
`default_nettype none
module fss_master_model
  import fss_pkg::*;
(
  input  wire logic     ref_clk_in,
  output var  fss_req_t req_out
);
  // ----------------------------------------
  // Request issue
  // ----------------------------------------
  initial req_out = '0;
  // setup before request
  // Clock flag good means clocks unused, or used and set up right
  task automatic send(input fss_state_t tgt, input logic [3:0] ok);
    logic dc_use;
    logic dc_rnd;
    dc_use = 1'($urandom);
    dc_rnd = 1'($urandom);
    @(posedge ref_clk_in) #1;
    req_out <= '{1'b1, tgt, ok[3], ok[2], dc_use | !ok[1], ok[1] & (dc_use | dc_rnd), ok[0]};
    @(posedge ref_clk_in) #1;
    // Released fields flip so a stale request never looks valid by accident
    req_out <= fss_req_t'({1'b0, ~req_out[7:0]});
  endtask : send
endmodule : fss_master_model
`default_nettype wire

// ---- tb/test_fieldbus_slave_state_machine.sv ----
// Testbench for the slave state machine: scripted requests against a bench model.
// Assumes fss_master_model issues requests and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_fieldbus_slave_state_machine;
  import fss_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, eack = 1'b0, wd_en = 1'b1, wd_trip = 1'b0, cyc = 1'b0;
  logic [15:0] phys = '0, mout = '0, dpm_exp, pout, dpm, idx;
  logic [7:0] chan = '0, sub = '0;
  logic [1:0] area = '0;
  logic [2:0] ecode;
  logic       ack, err, dpm_wr, sub_ok;
  int         bad_count = 0, compares = 0;
  fss_state_t st, state;
  fss_req_t   req;
  fss_perm_t  perm;
  // Script: target state, then setup flags {mailbox, data, clock, outputs}
  logic [6:0] plan [$] = '{{FSS_SAFE_OPERATIONAL_STATE, 4'hf}, {FSS_OP, 4'hf}, {FSS_PRE_OPERATIONAL_STATE, 4'h7},
    {FSS_PRE_OPERATIONAL_STATE, 4'hf}, {FSS_PRE_OPERATIONAL_STATE, 4'hf}, {FSS_BOOT, 4'hf}, {FSS_OP, 4'hf},
    {FSS_SAFE_OPERATIONAL_STATE, 4'hb}, {FSS_SAFE_OPERATIONAL_STATE, 4'hd}, {FSS_SAFE_OPERATIONAL_STATE, 4'hf}, {FSS_BOOT, 4'hf},
    {FSS_OP, 4'he}, {FSS_OP, 4'hf}, {FSS_OP, 4'hf}, {FSS_BOOT, 4'hf}, {3'h5, 4'hf},
    {FSS_SAFE_OPERATIONAL_STATE, 4'hf}, {FSS_PRE_OPERATIONAL_STATE, 4'hf}, {FSS_INIT, 4'hf}};
  fss_master_model master (.ref_clk_in(clk), .req_out(req));
  fss_slave_sm dut (.ref_clk_in(clk), .sys_rst_in(rst), .req_in(req), .err_ack_in(eack),
    .wdog_en_in(wd_en), .wdog_trip_in(wd_trip), .cycle_in(cyc), .phys_in(phys),
    .master_out_in(mout), .area_in(area), .chan_in(chan), .sub_in(sub), .state_out(state),
    .ack_out(ack), .err_out(err), .err_code_out(ecode), .perm_out(perm), .phys_out(pout),
    .dpm_in_out(dpm), .dpm_wr_out(dpm_wr), .index_out(idx), .sub_ok_out(sub_ok));
  // ----------------------------------------
  // Clock, model and tasks
  // ----------------------------------------
  always #5 clk = ~clk;
  // Refusal code expected for a request; zero when it is taken
  function automatic logic [2:0] exp_err(fss_state_t c, fss_state_t t, logic [3:0] ok);
    if (t == c || t == FSS_INIT) return 3'h0;
    if (c inside {FSS_SAFE_OPERATIONAL_STATE, FSS_OP} && t == FSS_PRE_OPERATIONAL_STATE) return 3'h0;
    if (c == FSS_OP && t == FSS_SAFE_OPERATIONAL_STATE) return 3'h0;
    if (c == FSS_INIT && t inside {FSS_PRE_OPERATIONAL_STATE, FSS_BOOT}) return ok[3] ? 3'h0 : 3'h2;
    if (c == FSS_PRE_OPERATIONAL_STATE && t == FSS_SAFE_OPERATIONAL_STATE) return !ok[2] ? 3'h3 : (ok[1] ? 3'h0 : 3'h4);
    if (c == FSS_SAFE_OPERATIONAL_STATE && t == FSS_OP) return ok[0] ? 3'h0 : 3'h5;
    return 3'h1;
  endfunction : exp_err
  task automatic tick;
    @(posedge clk) #1;
  endtask : tick
  task automatic reset_dut;
    rst = 1'b1;
    repeat (5) tick;
    rst = 1'b0;
    st = FSS_INIT;
    dpm_exp = '0;
    `CHK(state, FSS_INIT)
  endtask : reset_dut
  // Refresh pulse, then traffic, outputs and index once the state has settled
  task automatic settle;
    logic [15:0] p;
    logic live, safe;
    p = 16'($urandom);
    live = st inside {FSS_SAFE_OPERATIONAL_STATE, FSS_OP};
    safe = !live || (wd_en && (st == FSS_SAFE_OPERATIONAL_STATE || wd_trip));
    cyc <= 1'b1;
    phys <= p;
    tick;
    cyc <= 1'b0;
    if (live) dpm_exp = p;
    `CHK(dpm, dpm_exp)
    `CHK(dpm_wr, live)
    `CHK({perm.mbx_any, perm.pd}, {st != FSS_INIT && st != FSS_BOOT, live})
    `CHK(perm.mbx_file, st != FSS_INIT)
    if (st == FSS_BOOT) `CHK(perm, 3'h2)
    `CHK(pout, safe ? 16'h0000 : mout)
    p = area == 2'h1 ? 16'h6000 : (area == 2'h2 ? 16'h7000 : 16'h8000);
    `CHK(idx, p + {4'h0, chan, 4'h0})
    `CHK(sub_ok, 1'b1)
  endtask : settle
  task automatic step(input logic [6:0] p);
    fss_state_t t;
    logic [2:0] e;
    t = fss_state_t'(p[6:4]);
    e = exp_err(st, t, p[3:0]);
    {wd_en, wd_trip, area, chan, sub} = 20'($urandom);
    mout = 16'($urandom);
    master.send(t, p[3:0]);
    if (e != 3'h0) begin
      `CHK(err, 1'b1)
      `CHK(ecode, e)
      `CHK(state, st)
      `CHK(ack, 1'b0)
      eack = 1'b1;
      tick;
      eack = 1'b0;
      `CHK(err, 1'b0)
    end else begin
      `CHK(state, t)
      if (st == FSS_PRE_OPERATIONAL_STATE && t == FSS_SAFE_OPERATIONAL_STATE) begin
        `CHK(ack, 1'b0)
        tick;
        `CHK(dpm_wr, 1'b1)
        `CHK(dpm, phys)
        dpm_exp = phys;
      end
      `CHK(ack, 1'b1)
      st = t;
    end
    settle;
  endtask : step
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Main sequence: scripted walk twice, then the boot path after a reset
  initial begin
    void'($urandom(32'hcddf));
    repeat (2) begin
      reset_dut;
      foreach (plan[i]) step(plan[i]);
    end
    reset_dut;
    step({FSS_BOOT, 4'h7});
    step({FSS_BOOT, 4'hf});
    step({FSS_BOOT, 4'hf});
    step({FSS_PRE_OPERATIONAL_STATE, 4'hf});
    step({FSS_INIT, 4'hf});
    print_verdict;
  end
  // Watchdog well beyond the few microseconds the script needs
  initial begin
    #100us;
    bad_count++;
    print_verdict;
  end
endmodule : test_fieldbus_slave_state_machine
`default_nettype wire
